//--- design/cos_params.svh
`ifndef COS_PARAMS_SVH
`define COS_PARAMS_SVH
// Register word offsets
`define COS_ADDR_COMM 4'h0
`define COS_ADDR_UNIT 4'h1
`define COS_ADDR_XSRC 4'h2
`define COS_ADDR_XHI 4'h3
`define COS_ADDR_XLO 4'h4
`define COS_ADDR_MCAL 4'h5
`define COS_ADDR_TRAVEL 4'h6
`define COS_ADDR_DBAND 4'h7
`define COS_ADDR_RSP 4'h8
`define COS_ADDR_RHI 4'h9
`define COS_ADDR_RLO 4'ha
`define COS_ADDR_STAT 4'hb
`define COS_ADDR_SPLIM 4'hc
`define COS_ADDR_CTRL 4'hd
// Field positions in the framing register
`define COS_F_STOP 0
`define COS_F_LEN 1
`define COS_F_PAR 2
`define COS_F_RATE 4
// Reset values
`define COS_RST_STOP 1'h1
`define COS_RST_LEN 1'h0
`define COS_RST_UNIT 7'h00
`define COS_RST_TRAVEL 10'h01e
`define COS_RST_DBAND 14'h0000
`define COS_RST_RHI 16'h0514
`define COS_RST_RLO 16'hff38
// Ranges
`define COS_UNIT_MAX 7'h63
`define COS_TRAVEL_MIN 10'h001
`define COS_TRAVEL_MAX 10'h3e7
`define COS_DBAND_MAX 14'h270f
`define COS_MV_MIN_STD 16'hffce
`define COS_MV_MAX 16'h041a
`define COS_VO_MIN 16'hff9c
`define COS_VO_MAX 16'h044c
`define COS_ZERO16 16'h0000
`endif

//--- design/cos_pkg.sv
package cos_pkg;
  typedef enum logic [1:0] {COS_PAR_NONE = 2'h0, COS_PAR_EVEN = 2'h1, COS_PAR_ODD = 2'h2}
    cos_parity_t;
  typedef enum logic [2:0] {COS_BAUD_1K2 = 3'h0, COS_BAUD_2K4 = 3'h1, COS_BAUD_4K8 = 3'h2,
    COS_BAUD_9K6 = 3'h3, COS_BAUD_19K2 = 3'h4} cos_baud_t;
  typedef enum logic [2:0] {COS_SRC_SP = 3'h0, COS_SRC_RAMP = 3'h1, COS_SRC_PV = 3'h2,
    COS_SRC_MVH = 3'h3, COS_SRC_MVC = 3'h4, COS_SRC_VALVE = 3'h5} cos_src_t;
  typedef enum logic [1:0] {COS_CAL_IDLE = 2'h0, COS_CAL_RUN = 2'h1, COS_CAL_DONE = 2'h3}
    cos_cal_t;
endpackage

//--- design/cos_option_regs.sv
// Behaviour
// R01: framing and unit apply on reset or level change
// R02: stop bits one or two, default two
// R03: data length seven or eight, default seven
// R04: parity none, even, odd; default even
// R05: rate 1.2 to 19.2 kbps, default 9.6
// R06: unit number 0 to 99, default 0
// R07: retransmission source selector, default target value
// R08: linear scaling, inverted limits allowed
// R09: limit ranges per retransmission source
// R10: heat output in heat/cool forces lower zero
// R11: calibration command self-clears when done
// R12: calibration clears then reloads travel time
// R13: travel time 1 to 999 s, default 30
// R14: screen changes ignored during calibration
// R15: dead band 0 to 9999, valve held inside
// R16: external target enable, ramp forced active
// R17: external limits map 20/4 mA, defaults 1300/-200
// R18: general limit change overwrites external limits
// R19: tracking copies external into internal target
// R20: calibration mode only at security zero
// R21: operator holds mode key one second twice
// R22: out-of-range writes are rejected
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`include "cos_params.svh"
module cos_option_regs
  import cos_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic levelChange,
  input wire logic heatCoolMode,
  input wire logic calDone,
  input wire logic [9:0] calTravel,
  input wire logic [15:0] deviation,
  input wire logic [15:0] externalIn,
  input wire logic externalSel,
  input wire logic screenReq,
  input wire logic [1:0] security,
  input wire logic calModeReq,
  output logic activeStop2,
  output logic activeLen8,
  output logic [1:0] activeParity,
  output logic [2:0] activeRate,
  output logic [6:0] activeUnit,
  output logic [2:0] xferSrc,
  output logic calRunning,
  output logic screenAdvance,
  output logic valveHold,
  output logic externalMode,
  output logic rampActive,
  output logic [15:0] internalTarget,
  output logic calModeGrant
);
  // Settings written by software, plus handshake, calibration, tracking and synchroniser state
  logic stop2_r;
  logic len8_r;
  logic [1:0] parity_r;
  logic [2:0] rate_r;
  logic [6:0] unit_r;
  logic [2:0] src_r;
  logic [15:0] xHi_r;
  logic [15:0] xLo_r;
  logic [9:0] travel_r;
  logic [13:0] dband_r;
  logic rspEn_r;
  logic track_r;
  logic [15:0] rHi_r;
  logic [15:0] rLo_r;
  logic [15:0] spHi_r;
  logic [15:0] spLo_r;
  logic extSelPrev_r;
  logic [15:0] internal_r;
  logic ack_r;
  cos_cal_t cal_r;
  cos_cal_t cal_nxt;
  logic [1:0] secSync1_r;
  logic [1:0] secSync2_r;
  logic calDoneS1_r;
  logic calDoneS2_r;
  logic extSelS1_r;
  logic extSelS2_r;

  // Signed range test used by the retransmission and external limit checks
  function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo,
    input logic [15:0] hi);
    inRange = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction

  // Permitted range of the retransmission limits for a given source
  function automatic logic limitOk(input logic [2:0] s, input logic hc, input logic [15:0] v,
    input logic [15:0] spLo, input logic [15:0] spHi);
    case (s)
      COS_SRC_SP, COS_SRC_RAMP, COS_SRC_PV: limitOk = inRange(v, spLo, spHi);
      COS_SRC_MVH: limitOk = inRange(v, hc ? `COS_ZERO16 : `COS_MV_MIN_STD, `COS_MV_MAX); // [R09]
      COS_SRC_MVC: limitOk = inRange(v, `COS_ZERO16, `COS_MV_MAX); // [R09]
      COS_SRC_VALVE: limitOk = inRange(v, `COS_VO_MIN, `COS_VO_MAX); // [R09]
      default: limitOk = 1'b0;
    endcase
  endfunction

  // Write decode; one cycle of wait so reads come from flip-flops
  wire logic wrCycle = avsWrite & ack_r & clkEn;
  wire logic [15:0] wd = avsWriteData[15:0];
  wire logic wrComm = wrCycle && avsAddress == `COS_ADDR_COMM;
  wire logic wrUnit = wrCycle && avsAddress == `COS_ADDR_UNIT;
  wire logic wrSrc = wrCycle && avsAddress == `COS_ADDR_XSRC;
  wire logic wrXHi = wrCycle && avsAddress == `COS_ADDR_XHI;
  wire logic wrXLo = wrCycle && avsAddress == `COS_ADDR_XLO;
  wire logic wrCal = wrCycle && avsAddress == `COS_ADDR_MCAL;
  wire logic wrTravel = wrCycle && avsAddress == `COS_ADDR_TRAVEL;
  wire logic wrDband = wrCycle && avsAddress == `COS_ADDR_DBAND;
  wire logic wrRsp = wrCycle && avsAddress == `COS_ADDR_RSP;
  wire logic wrRHi = wrCycle && avsAddress == `COS_ADDR_RHI;
  wire logic wrRLo = wrCycle && avsAddress == `COS_ADDR_RLO;
  wire logic wrSpLim = wrCycle && avsAddress == `COS_ADDR_SPLIM;

  // Field validity
  wire logic [1:0] wPar = wd[`COS_F_PAR+1:`COS_F_PAR];
  wire logic [2:0] wRate = wd[`COS_F_RATE+2:`COS_F_RATE];
  wire logic commOk = wPar <= COS_PAR_ODD && wRate <= COS_BAUD_19K2; // [R04] [R05] [R22]
  wire logic unitOk = wd[15:7] == 9'h000 && wd[6:0] <= `COS_UNIT_MAX; // [R06] [R22]
  wire logic srcOk = wd[15:3] == 13'h0000 && wd[2:0] <= COS_SRC_VALVE // [R07]
    && (wd[2:0] != COS_SRC_MVC || heatCoolMode); // Cool output only in heat/cool
  wire logic forceLoZero = src_r == COS_SRC_MVH && heatCoolMode; // [R10]
  wire logic xHiOk = limitOk(src_r, heatCoolMode, wd, spLo_r, spHi_r); // [R22]
  wire logic xLoOk = limitOk(src_r, heatCoolMode, wd, spLo_r, spHi_r) && !forceLoZero;
  wire logic travelOk = wd[15:10] == 6'h00 && wd[9:0] >= `COS_TRAVEL_MIN
    && wd[9:0] <= `COS_TRAVEL_MAX; // [R13] [R22]
  wire logic dbandOk = wd[15:14] == 2'h0 && wd[13:0] <= `COS_DBAND_MAX; // [R15] [R22]
  wire logic rLimOk = inRange(wd, spLo_r, spHi_r); // [R22]
  wire logic spLimOk = $signed(avsWriteData[31:16]) >= $signed(wd);

  // Bus handshake: waitrequest drops one cycle after the request appears
  assign avsWaitRequest = (avsRead | avsWrite) & ~ack_r;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ack_r <= 1'b0;
    else if (clkEn)
      ack_r <= (avsRead | avsWrite) & ~ack_r;
  end

  // Two-stage synchronisers for inputs from outside logic
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      secSync1_r <= 2'h3;
      secSync2_r <= 2'h3;
      calDoneS1_r <= 1'b0;
      calDoneS2_r <= 1'b0;
      extSelS1_r <= 1'b0;
      extSelS2_r <= 1'b0;
    end
    else if (clkEn)
    begin
      secSync1_r <= security;
      secSync2_r <= secSync1_r;
      calDoneS1_r <= calDone;
      calDoneS2_r <= calDoneS1_r;
      extSelS1_r <= externalSel;
      extSelS2_r <= extSelS1_r;
    end
  end

  // Communication settings store
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      stop2_r <= `COS_RST_STOP; // [R02]
      len8_r <= `COS_RST_LEN; // [R03]
      parity_r <= COS_PAR_EVEN; // [R04]
      rate_r <= COS_BAUD_9K6; // [R05]
      unit_r <= `COS_RST_UNIT; // [R06]
    end
    else if (clkEn)
    begin
      if (wrComm && commOk)
      begin
        stop2_r <= wd[`COS_F_STOP];
        len8_r <= wd[`COS_F_LEN];
        parity_r <= wPar;
        rate_r <= wRate;
      end
      if (wrUnit && unitOk)
        unit_r <= wd[6:0];
    end
  end

  // Active framing follows only at reset or level change, so a link
  // in mid-frame is never reconfigured under the host
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      activeStop2 <= `COS_RST_STOP; // [R01]
      activeLen8 <= `COS_RST_LEN;
      activeParity <= COS_PAR_EVEN;
      activeRate <= COS_BAUD_9K6;
      activeUnit <= `COS_RST_UNIT;
    end
    else if (clkEn && levelChange)
    begin
      activeStop2 <= stop2_r; // [R01]
      activeLen8 <= len8_r;
      activeParity <= parity_r;
      activeRate <= rate_r;
      activeUnit <= unit_r;
    end
  end

  // Retransmission source and scale; limits may be inverted
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      src_r <= COS_SRC_SP; // [R07]
      xHi_r <= `COS_RST_RHI;
      xLo_r <= `COS_RST_RLO;
    end
    else if (clkEn)
    begin
      if (wrSrc && srcOk)
        src_r <= wd[2:0];
      if (wrXHi && xHiOk)
        xHi_r <= wd; // [R08]
      if (forceLoZero)
        xLo_r <= `COS_ZERO16; // [R10]
      else if (wrXLo && xLoOk)
        xLo_r <= wd; // [R08]
    end
  end
  assign xferSrc = src_r;

  // Motor calibration sequencer
  always_comb
  begin
    cal_nxt = cal_r;
    case (cal_r)
      COS_CAL_IDLE: if (wrCal && wd[0]) cal_nxt = COS_CAL_RUN; // [R11]
      COS_CAL_RUN: if (calDoneS2_r) cal_nxt = COS_CAL_DONE;
      COS_CAL_DONE: cal_nxt = COS_CAL_IDLE; // [R11]
      default: cal_nxt = COS_CAL_IDLE;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cal_r <= COS_CAL_IDLE;
    else if (clkEn)
      cal_r <= cal_nxt;
  end
  assign calRunning = cal_r != COS_CAL_IDLE;
  assign screenAdvance = screenReq & ~calRunning; // [R14]

  // Travel time: cleared on start, loaded from measurement at the end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      travel_r <= `COS_RST_TRAVEL; // [R13]
    else if (clkEn)
    begin
      if (cal_r == COS_CAL_IDLE && cal_nxt == COS_CAL_RUN)
        travel_r <= 10'h000; // [R12]
      else if (cal_r == COS_CAL_RUN && cal_nxt == COS_CAL_DONE)
        travel_r <= calTravel; // [R12]
      else if (wrTravel && travelOk && !calRunning)
        travel_r <= wd[9:0];
    end
  end

  // Dead band; magnitude of deviation compared against the band
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      dband_r <= `COS_RST_DBAND; // [R15]
    else if (clkEn && wrDband && dbandOk)
      dband_r <= wd[13:0];
  end
  wire logic [15:0] devAbs = deviation[15] ? 16'(-deviation) : deviation;
  assign valveHold = devAbs <= {2'h0, dband_r}; // [R15]

  // External target enable, tracking and limits
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rspEn_r <= 1'b0; // [R16]
      track_r <= 1'b0; // [R19]
      rHi_r <= `COS_RST_RHI; // [R17]
      rLo_r <= `COS_RST_RLO; // [R17]
      spHi_r <= `COS_RST_RHI;
      spLo_r <= `COS_RST_RLO;
    end
    else if (clkEn)
    begin
      if (wrRsp)
      begin
        rspEn_r <= wd[0];
        track_r <= wd[1];
      end
      if (wrSpLim && spLimOk)
      begin
        spHi_r <= avsWriteData[31:16];
        spLo_r <= wd;
        rHi_r <= avsWriteData[31:16]; // [R18]
        rLo_r <= wd; // [R18]
      end
      else
      begin
        if (wrRHi && rLimOk)
          rHi_r <= wd;
        if (wrRLo && rLimOk)
          rLo_r <= wd;
      end
    end
  end
  assign externalMode = rspEn_r & extSelS2_r; // [R16]
  assign rampActive = rspEn_r; // [R16]

  // External input scaled 4..20 mA onto lower..upper, input is 0..ffff
  // Top half nudged up one step so full scale lands exactly on the upper limit
  wire logic [16:0] extScaled = {1'b0, externalIn} + {16'h0000, externalIn[15]};
  wire logic signed [16:0] extSpan = $signed({rHi_r[15], rHi_r}) - $signed({rLo_r[15], rLo_r});
  wire logic signed [34:0] spanProd = $signed({1'b0, extScaled}) * extSpan; // [R17]
  wire logic [15:0] externalTarget = 16'($signed(rLo_r) + (spanProd >>> 16));

  // Internal target, with tracking on external-to-internal change
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      internal_r <= `COS_ZERO16;
      extSelPrev_r <= 1'b0;
    end
    else if (clkEn)
    begin
      extSelPrev_r <= externalMode;
      if (extSelPrev_r && !externalMode && track_r)
        internal_r <= externalTarget; // [R19]
    end
  end
  assign internalTarget = internal_r;

  // Calibration mode entry gate
  assign calModeGrant = calModeReq && secSync2_r == 2'h0; // [R20]

  // Read mux
  wire logic [31:0] rdMux =
    avsAddress == `COS_ADDR_COMM ? {25'h0, rate_r, parity_r, len8_r, stop2_r} :
    avsAddress == `COS_ADDR_UNIT ? {25'h0, unit_r} :
    avsAddress == `COS_ADDR_XSRC ? {29'h0, src_r} :
    avsAddress == `COS_ADDR_XHI ? {16'h0, xHi_r} :
    avsAddress == `COS_ADDR_XLO ? {16'h0, xLo_r} :
    avsAddress == `COS_ADDR_MCAL ? {31'h0, calRunning} :
    avsAddress == `COS_ADDR_TRAVEL ? {22'h0, travel_r} :
    avsAddress == `COS_ADDR_DBAND ? {18'h0, dband_r} :
    avsAddress == `COS_ADDR_RSP ? {30'h0, track_r, rspEn_r} :
    avsAddress == `COS_ADDR_RHI ? {16'h0, rHi_r} :
    avsAddress == `COS_ADDR_RLO ? {16'h0, rLo_r} :
    avsAddress == `COS_ADDR_STAT ? {28'h0, externalMode, rampActive, valveHold, calRunning} :
    avsAddress == `COS_ADDR_SPLIM ? {spHi_r, spLo_r} : 32'h0;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      avsReadData <= 32'h0;
    else if (clkEn && avsRead && !ack_r)
      avsReadData <= rdMux;
  end
endmodule

//--- dv/cos_checker.sv
module cos_checker
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] avsAddress,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic avsWaitRequest,
  input wire logic levelChange,
  input wire logic [2:0] activeRate,
  input wire logic [6:0] activeUnit,
  input wire logic calDone,
  input wire logic calRunning,
  input wire logic screenReq,
  input wire logic screenAdvance,
  input wire logic [15:0] deviation,
  input wire logic valveHold,
  input wire logic externalMode,
  input wire logic rampActive,
  input wire logic [1:0] security,
  input wire logic calModeReq,
  input wire logic calModeGrant
);
  timeunit 1ns;
  timeprecision 1ns;
  logic calStart_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Start command taken on the bus in the previous cycle
  always_ff @(posedge core_clk)
    calStart_r <= avsWrite && !avsWaitRequest && avsAddress == 4'h5 && avsWriteData[0];
  // Framing must not move on the write itself, only on a level change
  property p_frame_hold;
    !levelChange |=> $stable(activeRate) && $stable(activeUnit);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("active framing moved");
  property p_cal_start;
    $rose(calRunning) |-> calStart_r;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration began unasked");
  // Bound covers two synchroniser stages plus the done state
  property p_cal_end;
    calRunning && calDone |-> ##[1:8] !calRunning;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration never ended");
  property p_screen;
    screenAdvance == (screenReq && !calRunning);
  endproperty
  a_screen: assert property (p_screen) else $error("screen change during run");
  property p_dev_zero;
    deviation == 16'h0000 |-> valveHold;
  endproperty
  a_dev_zero: assert property (p_dev_zero) else $error("valve driven at zero error");
  property p_ramp;
    externalMode |-> rampActive;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp off in external mode");
  // Four cycles let the two-stage synchroniser settle
  property p_deny;
    (security != 2'h0) [*4] |-> !calModeGrant;
  endproperty
  a_deny: assert property (p_deny) else $error("calibration granted when locked");
  property p_grant;
    (security == 2'h0) [*4] ##0 calModeReq |-> calModeGrant;
  endproperty
  a_grant: assert property (p_grant) else $error("calibration refused when open");
endmodule

bind cos_option_regs cos_checker chkInst (.core_clk, .sys_rst, .avsAddress, .avsWrite,
  .avsWriteData, .avsWaitRequest, .levelChange, .activeRate, .activeUnit, .calDone, .calRunning,
  .screenReq, .screenAdvance, .deviation, .valveHold, .externalMode, .rampActive, .security,
  .calModeReq, .calModeGrant);

//--- dv/cos_host_model.sv
module cos_host_model
(
  input wire logic core_clk,
  output logic [3:0] avsAddress = 4'h0,
  output logic avsRead = 1'b0,
  output logic avsWrite = 1'b0,
  output logic [31:0] avsWriteData = 32'h0,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire logic calRunning,
  output logic calDone = 1'b0,
  output logic [9:0] calTravel = 10'h000
);
  timeunit 1ns;
  timeprecision 1ns;
  int runCycles = 20;
  logic [9:0] travelSeen = 10'h2a5;
  // Request held until a rising edge sees waitrequest low; data taken at that edge
  task automatic xfer(input logic isWr, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge core_clk);
    avsAddress <= a;
    avsWrite <= isWr;
    avsRead <= ~isWr;
    avsWriteData <= d;
    do
    begin
      @(posedge core_clk);
    end
    while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    avsAddress <= ~a;
    avsWriteData <= ~d;
  endtask
  // Motor reports the measured travel, held past the synchroniser, then lets it go
  initial
  forever
  begin
    @(posedge core_clk iff calRunning === 1'b1);
    repeat (runCycles) @(posedge core_clk);
    calDone <= 1'b1;
    calTravel <= travelSeen;
    repeat (4) @(posedge core_clk);
    calDone <= 1'b0;
    calTravel <= ~travelSeen;
    @(posedge core_clk iff calRunning === 1'b0);
  end
endmodule

//--- dv/tb.sv
module tb
  import cos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, levelChange = 1'b0;
  logic heatCoolMode = 1'b0, externalSel = 1'b0, screenReq = 1'b0, calModeReq = 1'b0;
  logic [1:0] security = 2'h0;
  logic [15:0] deviation = 16'h0000, externalIn = 16'h0000;
  logic avsRead, avsWrite, avsWaitRequest, calDone, activeStop2, activeLen8, calRunning;
  logic screenAdvance, valveHold, externalMode, rampActive, calModeGrant;
  logic [3:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, q;
  logic [9:0] calTravel;
  logic [1:0] activeParity;
  logic [2:0] activeRate, xferSrc;
  logic [6:0] activeUnit;
  logic [15:0] internalTarget;
  int n_errors = 0;
  int n_tests = 0;
  always #5 core_clk = ~core_clk;
  cos_option_regs DUT (.core_clk, .sys_rst, .clkEn, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsReadData, .avsWaitRequest, .levelChange, .heatCoolMode, .calDone,
    .calTravel, .deviation, .externalIn, .externalSel, .screenReq, .security, .calModeReq,
    .activeStop2, .activeLen8, .activeParity, .activeRate, .activeUnit, .xferSrc, .calRunning,
    .screenAdvance, .valveHold, .externalMode, .rampActive, .internalTarget, .calModeGrant);
  cos_host_model host (.core_clk, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsReadData, .avsWaitRequest, .calRunning, .calDone, .calTravel);
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Ends mid-cycle so registered outputs have settled before any check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk("register", q[15:0], e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic t_defaults;
    logic [3:0] adr [10] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'he};
    logic [15:0] val [10] = '{16'h35, 16'h0, 16'h0, 16'h0, 16'h1e, 16'h0, 16'h0, 16'h514,
      16'hff38, 16'h0};
    chk("frame", {activeRate, activeParity, activeLen8, activeStop2}, 16'h35);
    chk("parity", activeParity, COS_PAR_EVEN);
    chk("rate", activeRate, COS_BAUD_9K6);
    chk("unit", activeUnit, 16'h0);
    wr(4'he, 32'h1234);
    foreach (adr[i]) rd(adr[i], val[i]);
  endtask
  task automatic t_framing;
    logic [6:0] prev = 7'h35;
    logic [6:0] v;
    for (int i = 0; i < 5; i++)
    begin
      v = {3'(i), 2'(i % 3), i[0], ~i[0]};
      wr(4'h0, {25'h0, v});
      chk("frame", {activeRate, activeParity, activeLen8, activeStop2}, prev);
      @(posedge core_clk);
      levelChange <= 1'b1;
      @(posedge core_clk);
      levelChange <= 1'b0;
      cyc(1);
      chk("frame", {activeRate, activeParity, activeLen8, activeStop2}, v);
      prev = v;
    end
    wr(4'h0, 32'h55);
    wr(4'h0, 32'h4d);
    rd(4'h0, 16'h45);
    wr(4'h1, 32'h63);
    wr(4'h1, 32'h64);
    rd(4'h1, 16'h63);
  endtask
  task automatic t_xfer;
    @(posedge core_clk);
    heatCoolMode <= 1'b1;
    for (int s = 0; s < 6; s++)
    begin
      wr(4'h2, 32'(s));
      chk("source", xferSrc, 16'(s));
    end
    @(posedge core_clk);
    heatCoolMode <= 1'b0;
    wr(4'h2, 32'h4);
    chk("source", xferSrc, 16'h5);
    wr(4'h3, 32'hffffff9c);
    wr(4'h4, 32'h44c);
    wr(4'h3, 32'h44d);
    rd(4'h3, 16'hff9c);
    rd(4'h4, 16'h44c);
    @(posedge core_clk);
    heatCoolMode <= 1'b1;
    wr(4'h2, 32'h3);
    wr(4'h4, 32'hffffffce);
    rd(4'h4, 16'h0);
  endtask
  // Prompt motor first, then a slow one
  task automatic t_cal;
    wr(4'h6, 32'h3e7);
    wr(4'h6, 32'h3e8);
    wr(4'h6, 32'h0);
    rd(4'h6, 16'h3e7);
    @(posedge core_clk);
    screenReq <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      host.runCycles = 3 + 40 * k;
      host.travelSeen = 10'h2a5 - 10'(k);
      wr(4'h5, 32'h1);
      chk("running", calRunning, 16'h1);
      chk("screen", screenAdvance, 16'h0);
      rd(4'h6, 16'h0);
      for (int n = 0; n < 200 && calRunning !== 1'b0; n++) @(negedge core_clk);
      chk("screen", screenAdvance, 16'h1);
      rd(4'h5, 16'h0);
      rd(4'h6, 16'h2a5 - 16'(k));
    end
  endtask
  task automatic t_dband;
    logic [15:0] dv [4] = '{16'h64, 16'h65, 16'hff9c, 16'hff9b};
    wr(4'h7, 32'h64);
    wr(4'h7, 32'h2710);
    rd(4'h7, 16'h64);
    foreach (dv[i])
    begin
      @(posedge core_clk);
      deviation <= dv[i];
      cyc(0);
      chk("hold", valveHold, 16'(!i[0]));
    end
  endtask
  // Synchronised select: two cycles before the mode shows
  task automatic t_ext;
    @(posedge core_clk);
    externalSel <= 1'b1;
    externalIn <= 16'hffff;
    cyc(4);
    chk("external", externalMode, 16'h0);
    wr(4'h8, 32'h3);
    cyc(4);
    chk("external", externalMode, 16'h1);
    chk("ramp", rampActive, 16'h1);
    @(posedge core_clk);
    externalSel <= 1'b0;
    cyc(5);
    chk("target", internalTarget, 16'h514);
    wr(4'h8, 32'h1);
    @(posedge core_clk);
    externalSel <= 1'b1;
    externalIn <= 16'h0;
    cyc(5);
    @(posedge core_clk);
    externalSel <= 1'b0;
    cyc(5);
    chk("target", internalTarget, 16'h514);
    wr(4'hc, 32'h03e80000);
    rd(4'h9, 16'h3e8);
    rd(4'ha, 16'h0);
  endtask
  task automatic t_sec;
    @(posedge core_clk);
    security <= 2'h1;
    calModeReq <= 1'b1; // Stands in for the operator's long key hold
    cyc(5);
    chk("grant", calModeGrant, 16'h0);
    @(posedge core_clk);
    security <= 2'h0;
    cyc(5);
    chk("grant", calModeGrant, 16'h1);
  endtask
  // Clock enable low must freeze the level-change copy
  task automatic t_freeze;
    @(posedge core_clk);
    clkEn <= 1'b0;
    levelChange <= 1'b1;
    cyc(3);
    chk("unit", activeUnit, 16'h0);
    @(posedge core_clk);
    clkEn <= 1'b1;
    @(posedge core_clk);
    levelChange <= 1'b0;
    cyc(1);
    chk("unit", activeUnit, 16'h63);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_defaults();
    t_framing();
    t_xfer();
    t_cal();
    t_dband();
    t_ext();
    t_sec();
    t_freeze();
    stop_test();
  end
  // Whole run is about three hundred cycles
  initial
  begin
    #100us;
    n_errors++;
    stop_test();
  end
endmodule
